// file: src/csp_switch.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Drop to local sink only in slots marked in drop_channel_map.
// - Each outgoing channel copies the source named in space_channel_map.
// - Two underlying paths A and B form one protected channel.
// - Transmit side sends two copies of the protected source to A and B.
// - A path without server_signal_fail may serve as active source.
// - Active fails, standby healthy: standby becomes active.
// - Forward data, clock, frame start, fail of the active path only.
// - Hold a switch state naming path A or B as active.
// - Show protection_switch_state continuously on an output.
// - Frames are whole numbers of slots on every channel.
// - Term source passes data, clock, supervision insert; fail becomes ssf.
// - Term sink raises trail_signal_fail_action from incoming ssf.
// - Term sink raises server_fail_cause from incoming ssf and reports it.
// - Fault after 2.5 s steady cause, cleared after 10 s steady absence.
module csp_switch
	import csp_pkg::*;
#(
	parameter logic [31:0] SET_CYC = FLT_SET_CYC,
	parameter logic [31:0] CLR_CYC = FLT_CLR_CYC
) (
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// APB slave.
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	// Underlying receive path A.
	input  wire logic [DATA_W-1:0] a_data,
	input  wire logic              a_ck,
	input  wire logic              a_fs,
	input  wire logic              a_ssf,
	// Underlying receive path B.
	input  wire logic [DATA_W-1:0] b_data,
	input  wire logic              b_ck,
	input  wire logic              b_fs,
	input  wire logic              b_ssf,
	// Plain incoming channel.
	input  wire logic [DATA_W-1:0] x_data,
	input  wire logic              x_ck,
	input  wire logic              x_fs,
	input  wire logic              x_ssf,
	// Local channel-1 term source input.
	input  wire logic [DATA_W-1:0] src_data,
	input  wire logic              src_ck,
	input  wire logic              src_psi,
	input  wire logic              src_tsf,
	// Transmit copies toward paths A and B.
	output logic      [DATA_W-1:0] tx_a_data,
	output logic                   tx_a_ck,
	output logic                   tx_a_psi,
	output logic                   tx_a_ssf,
	output logic      [DATA_W-1:0] tx_b_data,
	output logic                   tx_b_ck,
	output logic                   tx_b_psi,
	output logic                   tx_b_ssf,
	// Outgoing space-switched channels.
	output logic      [DATA_W-1:0] out0_data,
	output logic                   out0_ck,
	output logic                   out0_fs,
	output logic                   out0_ssf,
	output logic      [DATA_W-1:0] out1_data,
	output logic                   out1_ck,
	output logic                   out1_fs,
	output logic                   out1_ssf,
	// Dropped channel toward the local sink.
	output logic      [DATA_W-1:0] drop_data,
	output logic                   drop_ck,
	output logic                   drop_fs,
	output logic                   drop_tsf,
	output logic                   drop_slot_hit,
	// Management outputs.
	output logic                   trail_signal_fail_action,
	output logic                   server_fail_cause,
	output logic                   server_fail_fault,
	output logic                   protection_switch_state
);

	// ****************************************************
	// Input resynchronisation
	// ****************************************************
	logic [CH_W-1:0] ch_a;
	logic [CH_W-1:0] ch_b;
	logic [CH_W-1:0] ch_x;
	logic [CH_W-1:0] ch_s;
	logic            rise_a;
	logic            rise_b;
	logic            rise_x;

	csp_chan_rx u_rx_a (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin_data(a_data),
		.pin_ck  (a_ck),
		.pin_fs  (a_fs),
		.pin_flag(a_ssf),
		.chan    (ch_a),
		.ck_rise (rise_a)
	);

	csp_chan_rx u_rx_b (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin_data(b_data),
		.pin_ck  (b_ck),
		.pin_fs  (b_fs),
		.pin_flag(b_ssf),
		.chan    (ch_b),
		.ck_rise (rise_b)
	);

	csp_chan_rx u_rx_x (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin_data(x_data),
		.pin_ck  (x_ck),
		.pin_fs  (x_fs),
		.pin_flag(x_ssf),
		.chan    (ch_x),
		.ck_rise (rise_x)
	);

	// The source side carries supervision insert in the frame slot.
	csp_chan_rx u_rx_s (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pin_data(src_data),
		.pin_ck  (src_ck),
		.pin_fs  (src_psi),
		.pin_flag(src_tsf),
		.chan    (ch_s),
		.ck_rise ()
	);

	// ****************************************************
	// Protection switch
	// ****************************************************
	csp_path_t       act_reg;
	logic [CH_W-1:0] ch_p;
	logic            rise_p;
	logic            sw_evt;
	logic            act_bad;
	logic            stby_bad;

	assign act_bad  = (act_reg == PATH_A) ? ch_a[CH_FLAG] : ch_b[CH_FLAG];
	assign stby_bad = (act_reg == PATH_A) ? ch_b[CH_FLAG] : ch_a[CH_FLAG];
	// A healthy standby is always acceptable, so a failed active moves.
	assign sw_evt   = act_bad & ~stby_bad;

	// Path A after reset; both failing leaves the choice alone.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			act_reg <= PATH_A;
		end else if (sw_evt) begin
			act_reg <= (act_reg == PATH_A) ? PATH_B : PATH_A;
		end
	end

	// Only the active path reaches the protected channel.
	assign ch_p   = (act_reg == PATH_A) ? ch_a : ch_b;
	assign rise_p = (act_reg == PATH_A) ? rise_a : rise_b;

	// ****************************************************
	// Registers
	// ****************************************************
	logic [8:0]      drop_reg;
	logic [3:0]      space_reg;
	logic [EV_W-1:0] istat_reg;
	logic [EV_W-1:0] ien_reg;
	logic [31:0]     prdata_reg;
	logic            pready_reg;
	logic            pslverr_reg;
	logic            wr_acc;
	logic            setup;
	logic            mapped;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;
	logic            fault;
	logic            cause_reg;

	assign setup  = psel & ~penable & ~pready_reg;
	assign wr_acc = psel & penable & pready_reg & pwrite;
	assign mapped = (paddr == OFS_DROP) || (paddr == OFS_SPACE) ||
		(paddr == OFS_STATUS) || (paddr == OFS_ISTAT) ||
		(paddr == OFS_IEN) || (paddr == OFS_ICLR);

	// Answer comes in the first access cycle; no wait states.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
		end
	end

	// Read data is sampled in the setup cycle so it leaves a flop.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prdata_reg <= '0;
		end else if (setup && !pwrite) begin
			case (paddr)
			OFS_DROP:   prdata_reg <= {23'h0, drop_reg};
			OFS_SPACE:  prdata_reg <= {28'h0, space_reg};
			OFS_STATUS: prdata_reg <= {27'h0, fault, cause_reg,
				ch_b[CH_FLAG], ch_a[CH_FLAG], act_reg == PATH_B};
			OFS_ISTAT:  prdata_reg <= {29'h0, istat_reg};
			OFS_IEN:    prdata_reg <= {29'h0, ien_reg};
			default:    prdata_reg <= '0;
			endcase
		end
	end

	// Map and enable registers steer the switch and the interrupt.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drop_reg  <= DROP_RST;
			space_reg <= SPACE_RST;
			ien_reg   <= '0;
		end else if (wr_acc) begin
			if (paddr == OFS_DROP)
				drop_reg <= pwdata[8:0];
			if (paddr == OFS_SPACE)
				space_reg <= pwdata[3:0];
			if (paddr == OFS_IEN)
				ien_reg <= pwdata[EV_W-1:0];
		end
	end

	// ****************************************************
	// Interrupts
	// ****************************************************
	logic fault_d_reg;
	logic irq_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fault_d_reg <= 1'b0;
		end else begin
			fault_d_reg <= fault;
		end
	end

	assign ev[EV_SWITCH]  = sw_evt;
	assign ev[EV_FLT_SET] = fault & ~fault_d_reg;
	assign ev[EV_FLT_CLR] = ~fault & fault_d_reg;
	assign clr = (wr_acc && paddr == OFS_ICLR) ? pwdata[EV_W-1:0] : '0;

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			istat_reg <= '0;
		end else begin
			istat_reg <= (istat_reg & ~clr) | ev;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(((istat_reg & ~clr) | ev) & ien_reg);
		end
	end

	// ****************************************************
	// Space switching
	// ****************************************************
	// Unused outputs carry no data and flag a server failure.
	function automatic logic [CH_W-1:0] pick(
		input logic [1:0]      code,
		input logic [CH_W-1:0] plain,
		input logic [CH_W-1:0] prot
	);
		case (code)
		SRC_PLAIN: pick = plain;
		SRC_PROT:  pick = prot;
		default:   pick = {{(CH_W-1){1'b0}}, 1'b1};
		endcase
	endfunction

	logic [CH_W-1:0] o0_reg;
	logic [CH_W-1:0] o1_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			o0_reg <= '0;
			o1_reg <= '0;
		end else begin
			o0_reg <= pick(space_reg[SPC0_LSB+:2], ch_x, ch_p);
			o1_reg <= pick(space_reg[SPC1_LSB+:2], ch_x, ch_p);
		end
	end

	// ****************************************************
	// Drop switching
	// ****************************************************
	logic [CH_W-1:0]   dsrc;
	logic              drise;
	logic [SLOT_W-1:0] slot_reg;
	logic [CH_W-1:0]   drop_reg_q;
	logic              hit_reg;
	logic              slot_on;

	assign dsrc  = drop_reg[DROP_SRC_BIT] ? ch_p : ch_x;
	assign drise = drop_reg[DROP_SRC_BIT] ? rise_p : rise_x;
	assign slot_on = drop_reg[dsrc[CH_FS] ? SLOT_W'(0) : slot_reg];

	// Slot index counts data clock edges; the frame start marks slot 0
	// and the count wraps, since frames hold whole slots only.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slot_reg <= '0;
		end else if (drise) begin
			if (dsrc[CH_FS])
				slot_reg <= SLOT_W'(1);
			else
				slot_reg <= slot_reg + SLOT_W'(1);
		end
	end

	// Data is caught at the slot's clock edge, so no later word leaks in.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			drop_reg_q <= '0;
			hit_reg    <= 1'b0;
		end else begin
			drop_reg_q[CH_FLAG+:3] <= dsrc[CH_FLAG+:3];
			if (drise) begin
				hit_reg <= slot_on;
				drop_reg_q[CH_DAT+:DATA_W] <= slot_on ?
					dsrc[CH_DAT+:DATA_W] : '0;
			end
		end
	end

	// ****************************************************
	// Channel-1 termination
	// ****************************************************
	logic tsf_reg;
	logic [CH_W-1:0] tx_reg;

	// Incoming server failure drives both action and cause.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tsf_reg   <= 1'b0;
			cause_reg <= 1'b0;
		end else begin
			tsf_reg   <= dsrc[CH_FLAG];
			cause_reg <= dsrc[CH_FLAG];
		end
	end

	csp_fault_timer #(
		.SET_CYC(SET_CYC),
		.CLR_CYC(CLR_CYC)
	) u_fault (
		.ref_clk(ref_clk),
		.rst    (rst),
		.cause  (cause_reg),
		.fault  (fault)
	);

	// Source pass-through, copied to both paths.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_reg <= '0;
		end else begin
			tx_reg <= ch_s;
		end
	end

	// ****************************************************
	// Output mapping
	// ****************************************************
	logic pss_reg;
	logic fault_q_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pss_reg     <= 1'b0;
			fault_q_reg <= 1'b0;
		end else begin
			pss_reg     <= (act_reg == PATH_B);
			fault_q_reg <= fault;
		end
	end

	assign prdata    = prdata_reg;
	assign pready    = pready_reg;
	assign pslverr   = pslverr_reg;
	assign irq       = irq_reg;
	assign tx_a_data = tx_reg[CH_DAT+:DATA_W];
	assign tx_a_ck   = tx_reg[CH_CK];
	assign tx_a_psi  = tx_reg[CH_FS];
	assign tx_a_ssf  = tx_reg[CH_FLAG];
	assign tx_b_data = tx_reg[CH_DAT+:DATA_W];
	assign tx_b_ck   = tx_reg[CH_CK];
	assign tx_b_psi  = tx_reg[CH_FS];
	assign tx_b_ssf  = tx_reg[CH_FLAG];
	assign out0_data = o0_reg[CH_DAT+:DATA_W];
	assign out0_ck   = o0_reg[CH_CK];
	assign out0_fs   = o0_reg[CH_FS];
	assign out0_ssf  = o0_reg[CH_FLAG];
	assign out1_data = o1_reg[CH_DAT+:DATA_W];
	assign out1_ck   = o1_reg[CH_CK];
	assign out1_fs   = o1_reg[CH_FS];
	assign out1_ssf  = o1_reg[CH_FLAG];
	assign drop_data = drop_reg_q[CH_DAT+:DATA_W];
	assign drop_ck   = drop_reg_q[CH_CK];
	assign drop_fs   = drop_reg_q[CH_FS];
	assign drop_tsf  = tsf_reg;
	assign drop_slot_hit            = hit_reg;
	assign trail_signal_fail_action = tsf_reg;
	assign server_fail_cause        = cause_reg;
	assign server_fail_fault        = fault_q_reg;
	assign protection_switch_state  = pss_reg;

endmodule
`default_nettype wire

// file: src/csp_pkg.sv
package csp_pkg;

	// ****************************************************
	// Channel bundle layout
	// ****************************************************
	localparam int DATA_W = 8;
	localparam int CH_W   = 11;
	localparam int CH_FLAG = 0;
	localparam int CH_FS   = 1;
	localparam int CH_CK   = 2;
	localparam int CH_DAT  = 3;

	// ****************************************************
	// Frame geometry
	// ****************************************************
	localparam int SLOTS  = 8;
	localparam int SLOT_W = 3;

	// ****************************************************
	// Register offsets (byte addresses)
	// ****************************************************
	localparam logic [7:0] OFS_DROP   = 8'h00;
	localparam logic [7:0] OFS_SPACE  = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_ISTAT  = 8'h0c;
	localparam logic [7:0] OFS_IEN    = 8'h10;
	localparam logic [7:0] OFS_ICLR   = 8'h14;

	// ****************************************************
	// Fields and reset values
	// ****************************************************
	localparam int DROP_SRC_BIT = 8;
	localparam int SPC0_LSB     = 0;
	localparam int SPC1_LSB     = 2;
	localparam int ST_PSS       = 0;
	localparam int ST_SSF_A     = 1;
	localparam int ST_SSF_B     = 2;
	localparam int ST_CAUSE     = 3;
	localparam int ST_FAULT     = 4;
	localparam int EV_SWITCH    = 0;
	localparam int EV_FLT_SET   = 1;
	localparam int EV_FLT_CLR   = 2;
	localparam int EV_W         = 3;
	localparam logic [8:0] DROP_RST  = 9'h000;
	localparam logic [3:0] SPACE_RST = 4'h0;

	// Space map source codes.
	localparam logic [1:0] SRC_NONE  = 2'h0;
	localparam logic [1:0] SRC_PLAIN = 2'h1;
	localparam logic [1:0] SRC_PROT  = 2'h2;

	// ****************************************************
	// Timing
	// ****************************************************
	localparam longint CLK_HZ      = 100000000;
	localparam longint FLT_SET_MS  = 2500;
	localparam longint FLT_CLR_MS  = 10000;
	localparam logic [31:0] FLT_SET_CYC =
		32'(FLT_SET_MS * (CLK_HZ / 1000));
	localparam logic [31:0] FLT_CLR_CYC =
		32'(FLT_CLR_MS * (CLK_HZ / 1000));

	typedef enum logic {PATH_A, PATH_B} csp_path_t;

endpackage

// file: src/csp_chan_rx.sv
`timescale 1ns/1ps
`default_nettype none
module csp_chan_rx
	import csp_pkg::*;
(
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// Channel pins from the foreign clock.
	input  wire logic [DATA_W-1:0] pin_data,
	input  wire logic              pin_ck,
	input  wire logic              pin_fs,
	input  wire logic              pin_flag,
	// Resynchronised bundle and data clock edge.
	output logic      [CH_W-1:0]   chan,
	output logic                   ck_rise
);

	logic [CH_W-1:0] s1_reg;
	logic [CH_W-1:0] s2_reg;
	logic            ck_d_reg;

	// Two stages on every pin; only the second stage is looked at.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= {pin_data, pin_ck, pin_fs, pin_flag};
			s2_reg <= s1_reg;
		end
	end

	// Edge finder on the settled copy of the data clock.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ck_d_reg <= 1'b0;
		end else begin
			ck_d_reg <= s2_reg[CH_CK];
		end
	end

	assign chan    = s2_reg;
	assign ck_rise = s2_reg[CH_CK] & ~ck_d_reg;

endmodule
`default_nettype wire

// file: src/csp_fault_timer.sv
`timescale 1ns/1ps
`default_nettype none
module csp_fault_timer
	import csp_pkg::*;
#(
	parameter logic [31:0] SET_CYC = FLT_SET_CYC,
	parameter logic [31:0] CLR_CYC = FLT_CLR_CYC
) (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic rst,
	// Cause in, integrated fault out.
	input  wire logic cause,
	output logic      fault
);

	logic [31:0] cnt_reg;
	logic        fault_reg;

	// The counter measures how long the cause has disagreed with the
	// fault; any agreement restarts it, so only a steady cause counts.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_reg   <= '0;
			fault_reg <= 1'b0;
		end else if (cause == fault_reg) begin
			cnt_reg <= '0;
		end else if (cause && cnt_reg >= SET_CYC - 32'h1) begin
			cnt_reg   <= '0;
			fault_reg <= 1'b1;
		end else if (!cause && cnt_reg >= CLR_CYC - 32'h1) begin
			cnt_reg   <= '0;
			fault_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
		end
	end

	assign fault = fault_reg;

endmodule
`default_nettype wire

// file: bench/csp_switch_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module csp_switch_chk
	import csp_pkg::*;
#(
	parameter logic [31:0] SET_CYC = FLT_SET_CYC,
	parameter logic [31:0] CLR_CYC = FLT_CLR_CYC
) (
	// Clock and reset.
	input wire logic              ref_clk,
	input wire logic              rst,
	// Bus handshake.
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pready,
	input wire logic              pslverr,
	// Path fails and local source.
	input wire logic              a_ssf,
	input wire logic              b_ssf,
	input wire logic [DATA_W-1:0] src_data,
	input wire logic              src_psi,
	input wire logic              src_tsf,
	// Outputs under watch.
	input wire logic [DATA_W-1:0] tx_a_data,
	input wire logic [DATA_W-1:0] tx_b_data,
	input wire logic              tx_a_psi,
	input wire logic              tx_a_ssf,
	input wire logic              tx_b_ssf,
	input wire logic              trail_signal_fail_action,
	input wire logic              server_fail_cause,
	input wire logic              server_fail_fault,
	input wire logic              protection_switch_state
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ****************************************************
	// Helper counters
	// ****************************************************
	logic [2:0]  age;
	logic [31:0] hi_cnt;
	logic [31:0] lo_cnt;

	// History taps still hold reset-time values until this saturates.
	always_ff @(posedge ref_clk) begin
		if (rst) age <= 3'h0;
		else if (age != 3'h7) age <= age + 3'h1;
	end
	// Length of the current run of the cause being high.
	always_ff @(posedge ref_clk) begin
		if (rst || !server_fail_cause) hi_cnt <= 32'h0;
		else hi_cnt <= hi_cnt + 32'h1;
	end
	// Length of the current run of the cause being low.
	always_ff @(posedge ref_clk) begin
		if (rst || server_fail_cause) lo_cnt <= 32'h0;
		else lo_cnt <= lo_cnt + 32'h1;
	end

	// ****************************************************
	// Properties
	// ****************************************************
	property p_ready;
		psel && !penable |=> pready;
	endproperty
	property p_err;
		pslverr |-> pready;
	endproperty
	property p_tx_data;
		age == 3'h7 |-> tx_a_data == $past(src_data, 3)
			&& tx_b_data == $past(src_data, 3);
	endproperty
	property p_tx_flag;
		age == 3'h7 |-> tx_a_psi == $past(src_psi, 3)
			&& tx_a_ssf == $past(src_tsf, 3) && tx_b_ssf == tx_a_ssf;
	endproperty
	property p_cause;
		trail_signal_fail_action == server_fail_cause;
	endproperty
	property p_flt_set;
		$rose(server_fail_fault) |-> hi_cnt >= SET_CYC - 32'h1
			&& hi_cnt <= SET_CYC + 32'h2;
	endproperty
	property p_flt_clr;
		$fell(server_fail_fault) |-> lo_cnt >= CLR_CYC - 32'h1
			&& lo_cnt <= CLR_CYC + 32'h2;
	endproperty
	property p_pss_rise;
		age == 3'h7 && $rose(protection_switch_state) |->
			$past(a_ssf, 4) && !$past(b_ssf, 4);
	endproperty
	property p_pss_fall;
		age == 3'h7 && $fell(protection_switch_state) |->
			$past(b_ssf, 4) && !$past(a_ssf, 4);
	endproperty
	property p_switch;
		(a_ssf && !b_ssf) [*6] |-> protection_switch_state;
	endproperty
	property p_hold;
		(a_ssf == b_ssf) [*6] |=> $stable(protection_switch_state);
	endproperty

	// A late answer would stall every master that trusts the handshake.
	a_ready: assert property (p_ready) else $error("no answer after setup");
	a_err: assert property (p_err) else $error("error without ready");
	a_tx_data: assert property (p_tx_data)
		else $error("transmit copy data differs");
	a_tx_flag: assert property (p_tx_flag)
		else $error("transmit copy flags differ");
	a_cause: assert property (p_cause)
		else $error("action and cause disagree");
	a_flt_set: assert property (p_flt_set)
		else $error("fault raised at wrong time");
	a_flt_clr: assert property (p_flt_clr)
		else $error("fault cleared at wrong time");
	a_pss_rise: assert property (p_pss_rise)
		else $error("switch to B without cause");
	a_pss_fall: assert property (p_pss_fall)
		else $error("switch to A without cause");
	a_switch: assert property (p_switch)
		else $error("healthy B not taken");
	a_hold: assert property (p_hold)
		else $error("switch state moved without cause");

	c_switch: cover property ($rose(protection_switch_state));
	c_fault: cover property ($rose(server_fail_fault));
	c_err: cover property (pslverr);
endmodule

bind csp_switch csp_switch_chk #(.SET_CYC(SET_CYC), .CLR_CYC(CLR_CYC)) u_chk (
	.ref_clk, .rst, .psel, .penable, .pready, .pslverr, .a_ssf, .b_ssf,
	.src_data, .src_psi, .src_tsf, .tx_a_data, .tx_b_data, .tx_a_psi,
	.tx_a_ssf, .tx_b_ssf, .trail_signal_fail_action, .server_fail_cause,
	.server_fail_fault, .protection_switch_state
);
`default_nettype wire

// file: bench/csp_chan_model.sv
`timescale 1ns/1ps
`default_nettype none
module csp_chan_model
	import csp_pkg::*;
#(
	parameter logic [DATA_W-1:0] BASE = 8'h10,
	parameter realtime           LAG  = 0.0
) (
	// Control from the bench.
	input  wire logic              run,
	input  wire logic              fail,
	// Channel pins toward the block.
	output logic      [DATA_W-1:0] data,
	output logic                   ck,
	output logic                   fs,
	output logic                   fail_o
);
	// Failure is a plain level from the far side.
	assign fail_o = fail;

	// Run is polled off the clock edge between frames; the data clock rests.
	initial begin
		data = BASE;
		ck = 1'b0;
		fs = 1'b0;
		#(LAG);
		forever begin
			while (run !== 1'b1) #10;
			for (int s = 0; s < SLOTS; s++) begin
				data = BASE + DATA_W'(s);
				fs = (s == 0);
				#80 ck = 1'b1;
				#80 ck = 1'b0;
			end
			fs = 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: bench/tb_channel_switch_protection.sv
`timescale 1ns/1ps
`default_nettype none
module tb_channel_switch_protection
	import csp_pkg::*;
;
	// ****************************************************
	// Signals
	// ****************************************************
	logic ref_clk = 1'b0, rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, irq, rerr;
	logic [DATA_W-1:0] a_data, b_data, x_data, src_data, tx_a_data, tx_b_data;
	logic [DATA_W-1:0] out0_data, out1_data, drop_data, last_hit = 8'h00;
	logic a_ck, a_fs, a_ssf, b_ck, b_fs, b_ssf, x_ck, x_fs, x_ssf;
	logic src_ck, src_psi, src_tsf, tx_a_ck, tx_a_psi, tx_a_ssf;
	logic tx_b_ck, tx_b_psi, tx_b_ssf, out0_ck, out0_fs, out0_ssf;
	logic out1_ck, out1_fs, out1_ssf, drop_ck, drop_fs, drop_tsf;
	logic drop_slot_hit, trail_signal_fail_action, server_fail_cause;
	logic server_fail_fault, protection_switch_state, hit_q = 1'b0;
	logic run_a = 0, run_b = 0, run_x = 0, run_s = 0;
	logic fail_a = 0, fail_b = 0, fail_x = 0, fail_s = 0;
	int   err_total = 0, compares = 0, hits = 0;

	// Short fault counts keep the run brief.
	csp_switch #(.SET_CYC(32'd20), .CLR_CYC(32'd40)) dut (.*);
	csp_chan_model #(.BASE(8'h10)) u_a (.run(run_a), .fail(fail_a),
		.data(a_data), .ck(a_ck), .fs(a_fs), .fail_o(a_ssf));
	csp_chan_model #(.BASE(8'h40), .LAG(3.3)) u_b (.run(run_b), .fail(fail_b),
		.data(b_data), .ck(b_ck), .fs(b_fs), .fail_o(b_ssf));
	csp_chan_model #(.BASE(8'h80), .LAG(5.1)) u_x (.run(run_x), .fail(fail_x),
		.data(x_data), .ck(x_ck), .fs(x_fs), .fail_o(x_ssf));
	csp_chan_model #(.BASE(8'hc0), .LAG(7.7)) u_s (.run(run_s), .fail(fail_s),
		.data(src_data), .ck(src_ck), .fs(src_psi), .fail_o(src_tsf));

	// 100 MHz system clock.
	always #5 ref_clk = ~ref_clk;

	// Counts drop windows and keeps the data seen as each one opens.
	always @(posedge ref_clk) begin
		hit_q <= drop_slot_hit;
		if (drop_slot_hit === 1'b1 && hit_q === 1'b0) begin
			hits <= hits + 1;
			last_hit <= drop_data;
		end
	end

	// ****************************************************
	// Tasks
	// ****************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// One bus transfer; waits for ready without assuming its delay.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(rdat, e, "read data");
		chk({31'h0, rerr}, {31'h0, ee}, "error flag");
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task test_done;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ****************************************************
	// Tests
	// ****************************************************
	initial begin
		run_s <= 1'b1;
		cyc(5);
		rst <= 1'b0;
		rd(OFS_DROP, 32'h0, 1'b0);
		rd(OFS_SPACE, 32'h0, 1'b0);
		rd(OFS_STATUS, 32'h0, 1'b0);
		rd(8'hfc, 32'h0, 1'b1);
		apb(1'b1, OFS_STATUS, 32'h1f);
		rd(OFS_STATUS, 32'h0, 1'b0);
		rd(OFS_ICLR, 32'h0, 1'b0);
		// Drop only slots 2 and 7 of one frame of the plain channel.
		apb(1'b1, OFS_DROP, 32'h084);
		rd(OFS_DROP, 32'h084, 1'b0);
		{run_a, run_b, run_x} <= 3'h7;
		cyc(20);
		{run_a, run_b, run_x} <= 3'h0;
		cyc(200);
		chk(hits, 2, "drop windows");
		chk(last_hit, 8'h87, "drop data");
		// Every source code on both outgoing channels; paths stand idle.
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, OFS_SPACE, {28'h0, c[1:0], c[1:0]});
			cyc(8);
			chk(out0_data, c == 1 ? x_data : c == 2 ? a_data : 8'h0, "o0");
			chk(out1_data, c == 1 ? x_data : c == 2 ? a_data : 8'h0, "o1");
			chk({out0_ssf, out1_ssf}, {2{c == 0 || c == 3}}, "fail");
		end
		// Fail A, then both, then heal A while B is still down.
		apb(1'b1, OFS_IEN, 32'h7);
		apb(1'b1, OFS_SPACE, 32'h2);
		fail_a <= 1'b1;
		cyc(10);
		chk(protection_switch_state, 1'b1, "to B");
		chk(out0_data, b_data, "B data");
		chk(out0_ssf, 1'b0, "B fail");
		rd(OFS_ISTAT, 32'h1, 1'b0);
		chk(irq, 1'b1, "irq on");
		fail_b <= 1'b1;
		cyc(10);
		chk(protection_switch_state, 1'b1, "both failed");
		fail_a <= 1'b0;
		cyc(10);
		chk(protection_switch_state, 1'b0, "to A");
		chk(out0_data, a_data, "A data");
		fail_b <= 1'b0;
		cyc(10);
		rd(OFS_STATUS, 32'h0, 1'b0);
		// Mask, unmask and clear the interrupt.
		apb(1'b1, OFS_IEN, 32'h0);
		cyc(2);
		chk(irq, 1'b0, "masked");
		apb(1'b1, OFS_IEN, 32'h1);
		cyc(2);
		chk(irq, 1'b1, "unmasked");
		apb(1'b1, OFS_ICLR, 32'h7);
		cyc(2);
		chk(irq, 1'b0, "cleared");
		rd(OFS_ISTAT, 32'h0, 1'b0);
		// Fail the dropped channel; fault must wait its full count.
		fail_x <= 1'b1;
		fail_s <= 1'b1;
		cyc(6);
		chk(trail_signal_fail_action, 1'b1, "action");
		chk(drop_tsf, 1'b1, "drop fail");
		chk(server_fail_cause, 1'b1, "cause");
		cyc(12);
		chk(server_fail_fault, 1'b0, "early fault");
		cyc(12);
		chk(server_fail_fault, 1'b1, "fault");
		rd(OFS_STATUS, 32'h18, 1'b0);
		fail_x <= 1'b0;
		cyc(30);
		chk(server_fail_fault, 1'b1, "early clear");
		cyc(20);
		chk(server_fail_fault, 1'b0, "clear");
		rd(OFS_ISTAT, 32'h6, 1'b0);
		// Transmit copies once the local source stands still.
		run_s <= 1'b0;
		cyc(200);
		chk(tx_a_data, src_data, "tx A data");
		chk(tx_b_data, src_data, "tx B data");
		chk({tx_b_ssf, tx_b_ck, tx_b_psi, tx_a_ck}, 4'h8, "tx flags");
		test_done;
	end

	// A hang ends the run through the same verdict.
	initial begin
		#200000;
		err_total++;
		$display("BAD %0t watchdog expired", $time);
		test_done;
	end
endmodule
`default_nettype wire
